//--- rtl/eeprom_map.sv
// dual-view user array with sector protection and system area
//
// Contract
// - The user array is sixteen sectors of thirty-two 32-bit blocks.
// - A contactless read or write is made only when its sector's security byte allows it; serial user reads are never refused.
// - A 64-bit unique identifier is held apart from user access and fed to the inventory.
// - Application family and storage format identifiers are held for anticollision.
// - Four 32-bit password blocks exist, one serial-bus and three contactless.
// - Contactless accesses are whole blocks checked against their sector's security byte.
// - An allowed contactless write replaces all 32 bits of the block at once.
// - The serial bus sees each sector as 128 separately readable and writable bytes.
// - A set serial-bus write-lock bit refuses serial writes into its sector until the serial password is presented.
// - Serial commands with the chip-enable select bit cleared go to the user array.
// - Block n maps onto serial byte addresses 4n to 4n+3, one byte lane each.
// - Each sector has a security byte, bits 7 to 5 zero, reset to zero.
// - With the select bit set the serial bus reads security bytes, one per byte address from 0 to 15.
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_map_defines.svh"
module eeprom_map #(
   parameter int SECTORS = 16,
   parameter int BLOCKS = 32,
   // arbitrary neutral identifier value
   parameter logic [63:0] UID_VALUE = 64'h0123456789ABCDEF
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // configuration bus
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // contactless block port
   input wire logic RF_REQ,
   input wire logic RF_WE,
   input wire logic [$clog2(SECTORS*BLOCKS)-1:0] RF_BLOCK,
   input wire eeprom_map_pkg::block_word_t RF_WDATA,
   output logic RF_ACK,
   output logic RF_DENIED,
   output eeprom_map_pkg::block_word_t RF_RDATA,
   // serial byte port
   input wire logic SB_REQ,
   input wire logic SB_WE,
   input wire logic SB_CHIP_ENABLE_SELECT_BIT,
   input wire logic [$clog2(SECTORS*BLOCKS)+1:0] SB_ADDR,
   input wire logic [7:0] SB_WDATA,
   output logic SB_ACK,
   output logic SB_DENIED,
   output logic [7:0] SB_RDATA,
   // password presentation
   input wire logic [31:0] PWD_CAND,
   input wire logic [1:0] PWD_CAND_SEL,
   input wire logic PWD_CAND_STB,
   input wire logic SESSION_END,
   output logic [3:0] PWD_GRANTED,
   // anticollision identifiers
   output logic [63:0] UNIQUE_TAG_IDENTIFIER,
   output logic [7:0] APPLICATION_FAMILY_ID,
   output logic [7:0] STORAGE_FORMAT_FAMILY_ID
);
   import eeprom_map_pkg::*;
   localparam int WORDS = SECTORS * BLOCKS;
   localparam int AW = $clog2(WORDS);
   localparam int BW = $clog2(BLOCKS);
   localparam int SW = $clog2(SECTORS);

   block_word_t mem [WORDS];
   sss_byte_t sss_q [SECTORS];
   block_word_t pwd_q [`PWD_SLOTS];
   logic [SECTORS-1:0] wlock_q;
   logic [7:0] afi_q;
   logic [7:0] storage_format_family_id_q;
   logic [3:0] grant_q;
   logic [15:0] rf_deny_cnt_q;
   logic [15:0] sb_deny_cnt_q;
   logic avs_ack_q;
   logic [31:0] avs_rdata_q;
   logic rf_ack_q, rf_den_q, sb_ack_q, sb_den_q;
   block_word_t rf_rdata_q;
   logic [7:0] sb_rdata_q;
   logic [SECTORS-1:0] rd_ok_v, wr_ok_v;
   logic rf_go, sb_go, rf_ok, sb_ok, sb_user_wr_ok, sss_in_range;
   logic [SW-1:0] rf_sector, sb_sector;
   logic [AW-1:0] sb_word;
   logic [1:0] sb_lane;
   acc_sel_t sel;
   logic [31:0] avs_rmux;

   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // one checker per sector security byte
   for (genvar k = 0; k < SECTORS; k++) begin : g_guard
      sector_guard u_guard (
         .sector_security_byte(sss_q[k]),
         .rf_grant(grant_q[3:1]),
         .rd_ok(rd_ok_v[k]),
         .wr_ok(wr_ok_v[k])
      );
   end

   // one access per cycle; contactless side wins a collision, serial waits
   assign rf_go = RF_REQ && !rf_ack_q;
   assign sb_go = SB_REQ && !sb_ack_q && !rf_go;
   assign sel = rf_go ? ACC_RF : (sb_go ? ACC_SB : ACC_IDLE);

   assign rf_sector = RF_BLOCK[AW-1:BW];
   assign rf_ok = RF_WE ? wr_ok_v[rf_sector] : rd_ok_v[rf_sector];

   // byte address splits into block and lane
   assign sb_word = SB_ADDR[AW+1:2];
   assign sb_lane = SB_ADDR[1:0];
   assign sb_sector = SB_ADDR[AW+1:BW+2];
   // write lock, lifted by the serial password
   assign sb_user_wr_ok = !(wlock_q[sb_sector] && !grant_q[`PWD_SERIAL_SLOT]);
   assign sss_in_range = (SB_ADDR < (AW+2)'(SECTORS));
   // select bit clear reaches user memory
   assign sb_ok = SB_CHIP_ENABLE_SELECT_BIT ? (!SB_WE && sss_in_range)
                                            : (!SB_WE || sb_user_wr_ok);

   // array port and answers
   always_ff @(posedge SYS_CLK) begin
      unique case (sel)
         ACC_RF: begin
            if (RF_WE && rf_ok) begin
               mem[RF_BLOCK] <= RF_WDATA;
            end
         end
         ACC_SB: begin
            if (SB_WE && sb_ok) begin
               mem[sb_word][8*sb_lane +: 8] <= SB_WDATA;
            end
         end
         ACC_IDLE: begin
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rf_ack_q <= 1'b0;
         rf_den_q <= 1'b0;
         rf_rdata_q <= '0;
         rf_deny_cnt_q <= `CNT_RESET;
      end else begin
         rf_ack_q <= (sel == ACC_RF);
         if (sel == ACC_RF) begin
            rf_den_q <= !rf_ok;
            // refused read returns zero rather than stale data
            rf_rdata_q <= (!RF_WE && rf_ok) ? mem[RF_BLOCK] : '0;
            if (!rf_ok) begin
               rf_deny_cnt_q <= rf_deny_cnt_q + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sb_ack_q <= 1'b0;
         sb_den_q <= 1'b0;
         sb_rdata_q <= 8'h00;
         sb_deny_cnt_q <= `CNT_RESET;
      end else begin
         sb_ack_q <= (sel == ACC_SB);
         if (sel == ACC_SB) begin
            sb_den_q <= !sb_ok;
            if (SB_WE || !sb_ok) begin
               sb_rdata_q <= 8'h00;
            end else if (SB_CHIP_ENABLE_SELECT_BIT) begin
               sb_rdata_q <= sss_q[SB_ADDR[SW-1:0]];
            end else begin
               sb_rdata_q <= mem[sb_word][8*sb_lane +: 8];
            end
            if (!sb_ok) begin
               sb_deny_cnt_q <= sb_deny_cnt_q + 16'h0001;
            end
         end
      end
   end

   // password grants: a match in the same cycle as session end still sets
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         grant_q <= 4'h0;
      end else begin
         for (int i = 0; i < `PWD_SLOTS; i++) begin
            if (PWD_CAND_STB && PWD_CAND_SEL == 2'(i) && PWD_CAND == pwd_q[i]) begin
               grant_q[i] <= 1'b1;
            end else if (SESSION_END) begin
               grant_q[i] <= 1'b0;
            end
         end
      end
   end

   // configuration bus: answer one cycle after the request appears
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !avs_ack_q;
   assign AVS_READDATA = avs_rdata_q;

   always_comb begin
      avs_rmux = 32'h00000000;
      if (AVS_ADDRESS == `REG_AFI) begin
         avs_rmux = {24'h000000, afi_q};
      end else if (AVS_ADDRESS == `REG_STORAGE_FORMAT_FAMILY_ID) begin
         avs_rmux = {24'h000000, storage_format_family_id_q};
      end else if (AVS_ADDRESS == `REG_WLOCK) begin
         avs_rmux[SECTORS-1:0] = wlock_q;
      end else if (AVS_ADDRESS == `REG_STATUS) begin
         avs_rmux = {sb_deny_cnt_q, rf_deny_cnt_q};
      end else begin
         // passwords read back as zero
         for (int w = 0; w < SECTORS / 4; w++) begin
            if (AVS_ADDRESS == `REG_SSS_BASE + 8'(4 * w)) begin
               avs_rmux = {sss_q[4*w+3], sss_q[4*w+2], sss_q[4*w+1], sss_q[4*w]};
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         avs_ack_q <= 1'b0;
         avs_rdata_q <= 32'h00000000;
      end else begin
         avs_ack_q <= (AVS_READ || AVS_WRITE) && !avs_ack_q;
         if (AVS_READ && !avs_ack_q) begin
            avs_rdata_q <= avs_rmux;
         end
      end
   end

   // system area, written at the accepting edge
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         afi_q <= `AFI_RESET;
         storage_format_family_id_q <= `STORAGE_FORMAT_FAMILY_ID_RESET;
         wlock_q <= '0;
         for (int i = 0; i < `PWD_SLOTS; i++) begin
            pwd_q[i] <= `PWD_RESET;
         end
         for (int k = 0; k < SECTORS; k++) begin
            sss_q[k] <= `SSS_RESET;
         end
      end else if (AVS_WRITE && avs_ack_q) begin
         if (AVS_ADDRESS == `REG_AFI && AVS_BYTEENABLE[0]) begin
            afi_q <= AVS_WRITEDATA[7:0];
         end
         if (AVS_ADDRESS == `REG_STORAGE_FORMAT_FAMILY_ID && AVS_BYTEENABLE[0]) begin
            storage_format_family_id_q <= AVS_WRITEDATA[7:0];
         end
         if (AVS_ADDRESS == `REG_WLOCK) begin
            wlock_q <= SECTORS'(merge(32'(wlock_q), AVS_WRITEDATA, AVS_BYTEENABLE));
         end
         for (int i = 0; i < `PWD_SLOTS; i++) begin
            if (AVS_ADDRESS == `REG_PWD_BASE + 8'(4 * i)) begin
               pwd_q[i] <= merge(pwd_q[i], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
         end
         for (int k = 0; k < SECTORS; k++) begin
            // top three bits never stored
            if (AVS_ADDRESS == `REG_SSS_BASE + 8'(4 * (k / 4)) && AVS_BYTEENABLE[k % 4]) begin
               sss_q[k] <= AVS_WRITEDATA[8*(k%4) +: 8] & `SSS_USED_MASK;
            end
         end
      end
   end

   // identifier only toward inventory, never the array ports
   assign UNIQUE_TAG_IDENTIFIER = UID_VALUE;
   assign APPLICATION_FAMILY_ID = afi_q;
   assign STORAGE_FORMAT_FAMILY_ID = storage_format_family_id_q;
   assign PWD_GRANTED = grant_q;
   assign RF_ACK = rf_ack_q;
   assign RF_DENIED = rf_den_q;
   assign RF_RDATA = rf_rdata_q;
   assign SB_ACK = sb_ack_q;
   assign SB_DENIED = sb_den_q;
   assign SB_RDATA = sb_rdata_q;

   // checks
   property p_rf_answer;
      @(posedge SYS_CLK) disable iff (!RST_B) (sel == ACC_RF) |=> RF_ACK ##1 !RF_ACK;
   endproperty
   a_rf_answer: assert property (p_rf_answer) else $error("rf answer timing wrong");

   property p_rf_whole;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (sel == ACC_RF && RF_WE && rf_ok) |=> mem[$past(RF_BLOCK)] == $past(RF_WDATA);
   endproperty
   a_rf_whole: assert property (p_rf_whole) else $error("block not fully written");

   property p_rf_locked;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (sel == ACC_RF && sss_q[rf_sector][`SSS_LOCK_BIT] && grant_q[3:1] == 3'b000)
         |=> RF_DENIED == $past(RF_WE || sss_q[rf_sector][`SSS_RDPROT_BIT]);
   endproperty
   a_rf_locked: assert property (p_rf_locked) else $error("locked sector verdict wrong");

   property p_sb_wlock;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (sel == ACC_SB && SB_WE && wlock_q[sb_sector] && !grant_q[0])
         |=> SB_ACK && SB_DENIED;
   endproperty
   a_sb_wlock: assert property (p_sb_wlock) else $error("locked serial write taken");

   property p_sb_lane;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (sel == ACC_SB && !SB_CHIP_ENABLE_SELECT_BIT && SB_WE && sb_ok)
         |=> mem[$past(sb_word)][8*$past(sb_lane) +: 8] == $past(SB_WDATA);
   endproperty
   a_sb_lane: assert property (p_sb_lane) else $error("serial byte lane wrong");

   property p_sb_user_read;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (sel == ACC_SB && !SB_CHIP_ENABLE_SELECT_BIT && !SB_WE)
         |=> !SB_DENIED && SB_RDATA == mem[$past(sb_word)][8*$past(sb_lane) +: 8];
   endproperty
   a_sb_user_read: assert property (p_sb_user_read) else $error("serial read wrong");

   property p_sss_view;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (sel == ACC_SB && SB_CHIP_ENABLE_SELECT_BIT && !SB_WE && sss_in_range)
         |=> SB_RDATA == sss_q[$past(SB_ADDR[SW-1:0])] && SB_RDATA[7:5] == 3'b000;
   endproperty
   a_sss_view: assert property (p_sss_view) else $error("security byte view wrong");

   property p_sss_upper;
      @(posedge SYS_CLK) disable iff (!RST_B) (sss_q[0] & ~`SSS_USED_MASK) == 8'h00;
   endproperty
   a_sss_upper: assert property (p_sss_upper) else $error("security byte top bits set");

   property p_avs_wait;
      @(posedge SYS_CLK) disable iff (!RST_B)
         $rose(AVS_READ) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 !avs_ack_q;
   endproperty
   a_avs_wait: assert property (p_avs_wait) else $error("bus answer not in one cycle");

   c_rf_write: cover property (@(posedge SYS_CLK) sel == ACC_RF && RF_WE && rf_ok);
   c_sb_refused: cover property (@(posedge SYS_CLK) SB_ACK && SB_DENIED);
   c_sss_read: cover property (@(posedge SYS_CLK) sel == ACC_SB && SB_CHIP_ENABLE_SELECT_BIT);
endmodule // eeprom_map
`default_nettype wire

//--- rtl/eeprom_map_defines.svh
// offsets, field positions and reset values of the sector map block
`ifndef EEPROM_MAP_DEFINES_SVH
`define EEPROM_MAP_DEFINES_SVH

// register byte offsets on the configuration bus
`define REG_AFI 8'h00
`define REG_STORAGE_FORMAT_FAMILY_ID 8'h04
`define REG_WLOCK 8'h08
`define REG_PWD_BASE 8'h10
`define REG_SSS_BASE 8'h20
`define REG_STATUS 8'h30

// sector security byte layout
`define SSS_LOCK_BIT 0
`define SSS_RDPROT_BIT 1
`define SSS_WRPROT_BIT 2
`define SSS_PWD_LSB 3
`define SSS_PWD_MSB 4
`define SSS_USED_MASK 8'h1F

// reset values
`define SSS_RESET 8'h00
`define AFI_RESET 8'h00
`define STORAGE_FORMAT_FAMILY_ID_RESET 8'h00
`define PWD_RESET 32'h00000000
`define CNT_RESET 16'h0000

// password slots: slot 0 serial bus, slots 1 to 3 contactless
`define PWD_SLOTS 4
`define PWD_SERIAL_SLOT 0

`endif

//--- rtl/eeprom_map_pkg.sv
// types shared by the sector map block
package eeprom_map_pkg;
   typedef logic [7:0] sss_byte_t;
   typedef logic [31:0] block_word_t;
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_RF = 2'b01,
      ACC_SB = 2'b10
   } acc_sel_t;
endpackage

//--- rtl/sector_guard.sv
// per-sector access check from the security byte and presented passwords
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_map_defines.svh"
module sector_guard (
   // security byte of the sector
   input wire eeprom_map_pkg::sss_byte_t sector_security_byte,
   // contactless passwords 1 to 3 presented this session
   input wire logic [2:0] rf_grant,
   // verdicts
   output logic rd_ok,
   output logic wr_ok
);
   import eeprom_map_pkg::*;
   logic locked;
   logic pwd_ok;
   logic [1:0] pwd_sel;

   assign locked = sector_security_byte[`SSS_LOCK_BIT];
   assign pwd_sel = sector_security_byte[`SSS_PWD_MSB:`SSS_PWD_LSB];

   // selector 0 names no password, so nothing can unlock it
   always_comb begin
      unique case (pwd_sel)
         2'b00: pwd_ok = 1'b0;
         2'b01: pwd_ok = rf_grant[0];
         2'b10: pwd_ok = rf_grant[1];
         2'b11: pwd_ok = rf_grant[2];
      endcase
   end

   assign rd_ok = !locked || !sector_security_byte[`SSS_RDPROT_BIT] || pwd_ok;
   // both protect bits set: write barred even with password
   assign wr_ok = !locked || (pwd_ok && !(sector_security_byte[`SSS_RDPROT_BIT] && sector_security_byte[`SSS_WRPROT_BIT]));
endmodule // sector_guard
`default_nettype wire

//--- verification/eeprom_map_test.sv
// self-checking bench for the sector map block
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_map_defines.svh"
module eeprom_map_test;
   import eeprom_map_pkg::*;
   // arbitrary identifier value
   localparam logic [63:0] UID_T = 64'h5A3C96E1F0B4D287;
   logic sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, pwd_cand = '0;
   logic [3:0] avs_byteenable = '0, pwd_granted;
   logic avs_waitrequest, pwd_cand_stb = 1'b0, session_end = 1'b0;
   logic [1:0] pwd_cand_sel = '0;
   logic rf_req, rf_we, rf_ack, rf_denied, sb_req, sb_we, sb_sel, sb_ack, sb_denied;
   logic [8:0] rf_block;
   logic [10:0] sb_addr;
   block_word_t rf_wdata, rf_rdata;
   logic [7:0] sb_wdata, sb_rdata, application_family_id, storage_format_family_id;
   logic [63:0] unique_tag_identifier;
   int err_count = 0, total_checks = 0, cyc = 0, seed = 48;
   // behavioural model
   logic [31:0] mem_m [int];
   sss_byte_t sss_m [16];
   logic [31:0] pw_m [4];
   logic [15:0] wl_m, rfd, sbd;
   logic [7:0] afi_m, storage_format_family_id_m;
   logic [3:0] gr_m;
   logic [31:0] r, pw1;
   logic [7:0] offs [11] = '{`REG_AFI, `REG_STORAGE_FORMAT_FAMILY_ID, `REG_WLOCK, 8'h10, 8'h14, 8'h20, 8'h24,
      8'h28, 8'h2C, `REG_STATUS, 8'h3C};
   always #2 sys_clk = ~sys_clk;
   eeprom_map #(.UID_VALUE(UID_T)) eeprom_map_i (.SYS_CLK(sys_clk), .RST_B(rst_b),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .RF_REQ(rf_req), .RF_WE(rf_we), .RF_BLOCK(rf_block), .RF_WDATA(rf_wdata),
      .RF_ACK(rf_ack), .RF_DENIED(rf_denied), .RF_RDATA(rf_rdata),
      .SB_REQ(sb_req), .SB_WE(sb_we), .SB_CHIP_ENABLE_SELECT_BIT(sb_sel), .SB_ADDR(sb_addr),
      .SB_WDATA(sb_wdata), .SB_ACK(sb_ack), .SB_DENIED(sb_denied), .SB_RDATA(sb_rdata),
      .PWD_CAND(pwd_cand), .PWD_CAND_SEL(pwd_cand_sel), .PWD_CAND_STB(pwd_cand_stb),
      .SESSION_END(session_end), .PWD_GRANTED(pwd_granted), .UNIQUE_TAG_IDENTIFIER(unique_tag_identifier),
      .APPLICATION_FAMILY_ID(application_family_id), .STORAGE_FORMAT_FAMILY_ID(storage_format_family_id));
   link_partner link_partner_i (.clk(sys_clk), .rf_req(rf_req), .rf_we(rf_we),
      .rf_block(rf_block), .rf_wdata(rf_wdata), .rf_ack(rf_ack), .rf_denied(rf_denied),
      .rf_rdata(rf_rdata), .sb_req(sb_req), .sb_we(sb_we), .sb_sel(sb_sel),
      .sb_addr(sb_addr), .sb_wdata(sb_wdata), .sb_ack(sb_ack), .sb_denied(sb_denied),
      .sb_rdata(sb_rdata));
   task automatic stop_test;
      if (err_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         stop_test;
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic mreset;
      foreach (sss_m[i]) sss_m[i] = `SSS_RESET;
      foreach (pw_m[i]) pw_m[i] = `PWD_RESET;
      {wl_m, rfd, sbd, afi_m, storage_format_family_id_m, gr_m} = '0;
   endtask
   task automatic avs(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
      input logic [3:0] be, output logic [31:0] rd);
      @(posedge sys_clk);
      avs_address <= ad;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      @(posedge sys_clk);
      // hold the request until waitrequest is sampled low at a rising edge
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic avs_w(input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] be);
      avs(1'b1, ad, wd, be, r);
      if (ad == `REG_AFI && be[0]) afi_m = wd[7:0];
      if (ad == `REG_STORAGE_FORMAT_FAMILY_ID && be[0]) storage_format_family_id_m = wd[7:0];
      for (int j = 0; j < 2; j++) if (ad == `REG_WLOCK && be[j]) wl_m[8*j+:8] = wd[8*j+:8];
      if (ad[7:4] == 4'h1) pw_m[ad[3:2]] = wd;
      for (int j = 0; j < 4; j++)
         if (ad[7:4] == 4'h2 && be[j]) sss_m[4*ad[3:2]+j] = wd[8*j+:8] & `SSS_USED_MASK;
   endtask
   task automatic avs_chk(input logic [7:0] ad);
      logic [31:0] e;
      e = '0;
      avs(1'b0, ad, '0, 4'hF, r);
      if (ad == `REG_AFI) e = afi_m;
      if (ad == `REG_STORAGE_FORMAT_FAMILY_ID) e = storage_format_family_id_m;
      if (ad == `REG_WLOCK) e = wl_m;
      if (ad[7:4] == 4'h2) e = {sss_m[4*ad[3:2]+3], sss_m[4*ad[3:2]+2],
         sss_m[4*ad[3:2]+1], sss_m[4*ad[3:2]]};
      if (ad == `REG_STATUS) e = {sbd, rfd};
      chk(r, e);
   endtask
   task automatic rf_t(input logic we, input logic [8:0] b, input logic [31:0] wd);
      logic ok, dn;
      logic [31:0] rd;
      sss_byte_t s;
      s = sss_m[b >> 5];
      ok = !s[0] || (we ? (s[2:1] != 2'b11 && s[4:3] != 0 && gr_m[s[4:3]])
         : (!s[1] || (s[4:3] != 0 && gr_m[s[4:3]])));
      link_partner_i.rf_op(we, b, wd, dn, rd);
      chk(dn, !ok);
      if (!ok) rfd++;
      if (ok && we) mem_m[b] = wd;
      chk(rd, (ok && !we) ? mem_m[b] : 32'h0);
   endtask
   task automatic sb_t(input logic we, input logic ce, input logic [10:0] a,
      input logic [7:0] wd);
      logic ok, dn;
      logic [7:0] rd, e;
      ok = ce ? (!we && a < 16) : (!we || !wl_m[a >> 7] || gr_m[0]);
      link_partner_i.sb_op(we, ce, a, wd, dn, rd);
      chk(dn, !ok);
      if (!ok) sbd++;
      e = '0;
      if (ok && ce) e = sss_m[a];
      if (ok && !ce && we) mem_m[a >> 2][8*a[1:0]+:8] = wd;
      if (ok && !ce && !we) e = mem_m[a >> 2][8*a[1:0]+:8];
      chk(rd, e);
   endtask
   task automatic pwd(input logic [1:0] sl, input logic [31:0] v, input logic fin);
      @(posedge sys_clk);
      pwd_cand <= v;
      pwd_cand_sel <= sl;
      pwd_cand_stb <= !fin;
      session_end <= fin;
      @(posedge sys_clk);
      pwd_cand_stb <= 1'b0;
      session_end <= 1'b0;
      if (fin) gr_m = '0;
      else if (v === pw_m[sl]) gr_m[sl] = 1'b1;
      @(negedge sys_clk);
      chk(pwd_granted, gr_m);
   endtask
   initial begin
      mreset();
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      chk(unique_tag_identifier, UID_T);
      foreach (offs[i]) avs_chk(offs[i]);
      avs_w(`REG_AFI, $random(seed), 4'h1);
      avs_w(`REG_STORAGE_FORMAT_FAMILY_ID, $random(seed), 4'h1);
      // write lands at the accepting edge, look once it has settled
      @(negedge sys_clk);
      chk(application_family_id, afi_m);
      chk(storage_format_family_id, storage_format_family_id_m);
      avs_chk(`REG_STORAGE_FORMAT_FAMILY_ID);
      // blocks written whole, seen as four byte lanes
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         rf_t(1'b1, r[8:0], $random(seed));
         rf_t(1'b0, r[8:0], '0);
         for (int j = 0; j < 4; j++) sb_t(1'b0, 1'b0, {r[8:0], j[1:0]}, '0);
      end
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         sb_t(1'b1, 1'b0, r[10:0], r[18:11]);
         rf_t(1'b0, r[10:2], '0);
      end
      avs_w(`REG_WLOCK, 32'h0008, 4'h3);
      sb_t(1'b1, 1'b0, 11'h185, 8'hA5);
      pwd(2'd0, 32'h0, 1'b0);
      sb_t(1'b1, 1'b0, 11'h185, 8'h3C);
      sb_t(1'b0, 1'b0, 11'h185, '0);
      pwd(2'd0, '0, 1'b1);
      sb_t(1'b1, 1'b0, 11'h186, 8'h77);
      pw1 = $random(seed);
      avs_w(8'h14, pw1, 4'hF);
      avs_w(8'h24, 32'h0000_0900, 4'h2);
      rf_t(1'b1, 9'd162, $random(seed));
      rf_t(1'b0, 9'd162, '0);
      pwd(2'd1, ~pw1, 1'b0);
      pwd(2'd1, pw1, 1'b0);
      rf_t(1'b1, 9'd162, $random(seed));
      avs_w(8'h24, 32'h0000_0F00, 4'h2);
      rf_t(1'b1, 9'd162, $random(seed));
      rf_t(1'b0, 9'd162, '0);
      pwd(2'd1, '0, 1'b1);
      rf_t(1'b0, 9'd162, '0);
      avs_w(8'h20, 32'hFFFF_FFFF, 4'hF);
      avs_chk(8'h20);
      // security bytes behind the select bit
      for (int a = 0; a < 17; a++) sb_t(1'b0, 1'b1, a[10:0], '0);
      sb_t(1'b1, 1'b1, 11'h0, 8'h55);
      fork
         rf_t(1'b0, 9'd162, '0);
         sb_t(1'b0, 1'b0, 11'h288, '0);
      join
      avs_chk(`REG_STATUS);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      @(posedge sys_clk);
      rst_b <= 1'b1;
      mreset();
      avs_chk(8'h24);
      avs_chk(`REG_WLOCK);
      stop_test;
   end
endmodule // eeprom_map_test
`default_nettype wire

//--- verification/link_partner.sv
// reader and serial master model driving the block ports
`timescale 1ns/10ps
`default_nettype none
module link_partner (
   // clock
   input wire logic clk,
   // contactless reader
   output logic rf_req,
   output logic rf_we,
   output logic [8:0] rf_block,
   output logic [31:0] rf_wdata,
   input wire logic rf_ack,
   input wire logic rf_denied,
   input wire logic [31:0] rf_rdata,
   // serial master
   output logic sb_req,
   output logic sb_we,
   output logic sb_sel,
   output logic [10:0] sb_addr,
   output logic [7:0] sb_wdata,
   input wire logic sb_ack,
   input wire logic sb_denied,
   input wire logic [7:0] sb_rdata
);
   initial begin
      {rf_req, rf_we, rf_block, rf_wdata} = '0;
      {sb_req, sb_we, sb_sel, sb_addr, sb_wdata} = '0;
   end
   task automatic rf_op(input logic we, input logic [8:0] b, input logic [31:0] wd,
      output logic dn, output logic [31:0] rd);
      @(posedge clk);
      rf_req <= 1'b1;
      rf_we <= we;
      rf_block <= b;
      rf_wdata <= wd;
      @(posedge clk);
      while (rf_ack !== 1'b1) @(posedge clk);
      dn = rf_denied;
      rd = rf_rdata;
      rf_req <= 1'b0;
      // released lines show no stale value
      rf_block <= ~b;
      rf_wdata <= ~wd;
   endtask
   // select bit follows ce: cleared for user array, set for security bytes
   task automatic sb_op(input logic we, input logic ce, input logic [10:0] a,
      input logic [7:0] wd, output logic dn, output logic [7:0] rd);
      @(posedge clk);
      sb_req <= 1'b1;
      sb_we <= we;
      sb_sel <= ce;
      sb_addr <= a;
      sb_wdata <= wd;
      @(posedge clk);
      while (sb_ack !== 1'b1) @(posedge clk);
      dn = sb_denied;
      rd = sb_rdata;
      sb_req <= 1'b0;
      sb_addr <= ~a;
      sb_wdata <= ~wd;
   endtask
endmodule // link_partner
`default_nettype wire
